// ===== design/ntx_pkg.sv
// constants, types and register map of the nfc transmit/transceive control block
//------------------------------------------------------------
// Notes on behaviour
// - four-bit depth field picks one of 16 even AM steps, 5 to 30 percent
// - all-zero transition pattern means normal drive on every cycle after a transition
// - pattern bit one: mode 00 driver supply, 01 modulation supply, 10 outputs stopped
// - pattern bit n drives carrier cycle n+1 after modulated-to-unmodulated, 14 cycles
// - from the fifteenth carrier cycle the normal driver settings apply again
// - a second pattern shapes unmodulated-to-modulated transitions the same way
// - global enable starts oscillator and regulators; stable oscillator sets a flag
// - end-of-transmission flag after the last frame byte is sent
// - after transmit the receiver watches rf, starts rssi and optional agc
// - received bytes go to fifo; end-of-receive flag; fifo count readable
// - reception error or bit collision sets its own flag
// - flag when unsent fifo bytes drop below the transmit water level
// - flag when fifo holds more bytes than the receive water level
// - target role bit selects listen operation; mode field picks the variant
// - mode msb zero runs fixed listen; low bits choose the technology
// - automatic type-A anticollision up to SAK; type F answers only SENSF_REQ
// - go-to-sense and go-to-sleep move target state; wake and request set flags
// - automatic response bytes come from the host-loaded target memory
// - mode msb one runs bit rate detection over the enabled technologies
//------------------------------------------------------------
package ntx_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TXCFG = 8'h04;
	localparam logic [7:0] REG_OVPAT = 8'h08;
	localparam logic [7:0] REG_UNPAT = 8'h0c;
	localparam logic [7:0] REG_CMD = 8'h10;
	localparam logic [7:0] REG_NTX = 8'h14;
	localparam logic [7:0] REG_WLVL = 8'h18;
	localparam logic [7:0] REG_STAT = 8'h1c;
	localparam logic [7:0] REG_FLAGS = 8'h20;
	localparam logic [7:0] REG_FIFO = 8'h24;
	localparam logic [7:0] REG_PTMEM = 8'h28;
	// flag bit positions
	localparam int FL_OSC = 0;
	localparam int FL_EOT = 1;
	localparam int FL_EOR = 2;
	localparam int FL_ERR = 3;
	localparam int FL_COLL = 4;
	localparam int FL_TXWL = 5;
	localparam int FL_RXWL = 6;
	localparam int FL_WUA = 7;
	localparam int FL_WUF = 8;
	localparam int NFLAG = 9;
	// commands
	localparam logic [3:0] CMD_STOP = 4'h1;
	localparam logic [3:0] CMD_TX = 4'h2;
	localparam logic [3:0] CMD_REQA = 4'h3;
	localparam logic [3:0] CMD_WUPA = 4'h4;
	localparam logic [3:0] CMD_SENSE = 4'h5;
	localparam logic [3:0] CMD_SLEEP = 4'h6;
	localparam logic [7:0] BYTE_REQA = 8'h26;
	localparam logic [7:0] BYTE_WUPA = 8'h52;
	// target memory layout
	localparam logic [5:0] PT_SENS_RES = 6'h0a;
	localparam logic [5:0] PT_SAK = 6'h0c;
	localparam logic [5:0] PT_SENSF = 6'h11;
	localparam logic [9:0] LEN_SENS_RES = 10'h002;
	localparam logic [9:0] LEN_SAK = 10'h001;
	localparam logic [9:0] LEN_SENSF = 10'h013;
	localparam int PT_DEPTH = 48;
	localparam int FIFO_DEPTH = 512;
	localparam int PAT_LEN = 14;
	// timing
	localparam int CLK_PS = 4000;
	localparam int CARRIER_PS = 73746;
	localparam int CARR_CYC = CARRIER_PS / CLK_PS;
	localparam logic [6:0] CARR_PER_BIT = 7'h7f;
	// reset values
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;

	typedef enum logic [3:0] {
		DRV_OFF = 4'b0001, DRV_DR = 4'b0010, DRV_AM = 4'b0100, DRV_STOP = 4'b1000
	} ntx_drv_e;
	typedef enum logic [2:0] {E_IDLE = 3'b001, E_TX = 3'b010, E_RX = 3'b100} ntx_eng_e;
	typedef enum logic [3:0] {
		PT_SENSE = 4'b0001, PT_READY = 4'b0010, PT_ACTIVE = 4'b0100, PT_SLEEP = 4'b1000
	} ntx_pt_e;
	typedef enum logic [2:0] {SRC_FIFO = 3'b001, SRC_PT = 3'b010, SRC_FIX = 3'b100} ntx_src_e;

	typedef struct packed {
		logic agc_en;
		logic [3:0] operating_mode_field;
		logic targ;
		logic tx_en;
		logic rx_en;
		logic en;
	} ntx_ctrl_s;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic done;
		logic err;
		logic coll;
	} ntx_rx_evt_s;
	typedef struct packed {
		logic reqa;
		logic wupa;
		logic sel;
		logic sensf_req;
	} ntx_pt_evt_s;
endpackage

// ===== design/ntx_core.sv
// nfc front-end control: register slave, transceive engine, drive shaping, target logic
`timescale 1ns/1ps
module ntx_core (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// axi4-lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// analog front end
	input wire logic osc_stable_i,
	input wire ntx_pkg::ntx_rx_evt_s rx_evt_i,
	input wire ntx_pkg::ntx_pt_evt_s pt_evt_i,
	output logic osc_en_o,
	output logic [3:0] modulation_depth_sel_o,
	output ntx_pkg::ntx_drv_e drv_o,
	output logic rx_watch_o,
	output logic rssi_start_o,
	output logic agc_run_o,
	// listen mode selection and interrupt
	output logic listen_o,
	output logic fixed_listen_o,
	output logic bitrate_det_o,
	output logic [2:0] tech_o,
	output logic irq_o
);
	import ntx_pkg::*;

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	ntx_ctrl_s ctrl_q;
	logic [7:0] txcfg_q;
	logic [PAT_LEN-1:0] ovpat_q, unpat_q;
	logic [9:0] ntx_q;
	logic [8:0] txwl_q, rxwl_q;
	logic [NFLAG-1:0] flags_q, flag_set, flag_clr;
	logic [7:0] ptm [PT_DEPTH];
	logic [7:0] fifo [FIFO_DEPTH];
	logic [8:0] wr_ptr_q, rd_ptr_q;
	logic [9:0] fcnt_q;
	ntx_eng_e eng_q;
	ntx_pt_e pt_q;
	logic osc_s1_q, osc_s2_q, osc_ok_q;

	//------------------------------------------------------------
	// axi4-lite slave
	//------------------------------------------------------------
	logic aw_have_q, w_have_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic wr_go, rd_go, wr_hit, rd_hit;
	logic [31:0] rd_val;

	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
	assign rd_go = s_axi_arvalid && s_axi_arready;
	assign wr_hit = awaddr_q <= REG_PTMEM && awaddr_q[1:0] == 2'b00 && awaddr_q != REG_STAT;
	assign rd_hit = s_axi_araddr <= REG_PTMEM && s_axi_araddr[1:0] == 2'b00;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= RST_ZERO;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				wdata_q <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_comb begin
		rd_val = RST_ZERO;
		unique case (s_axi_araddr)
			REG_CTRL: rd_val = {23'h0, ctrl_q};
			REG_TXCFG: rd_val = {24'h0, txcfg_q};
			REG_OVPAT: rd_val = {18'h0, ovpat_q};
			REG_UNPAT: rd_val = {18'h0, unpat_q};
			REG_NTX: rd_val = {22'h0, ntx_q};
			REG_WLVL: rd_val = {7'h0, rxwl_q, 7'h0, txwl_q};
			REG_STAT: rd_val = {14'h0, pt_q, fcnt_q, eng_q, osc_ok_q};
			REG_FLAGS: rd_val = {23'h0, flags_q};
			REG_FIFO: rd_val = {24'h0, fifo[rd_ptr_q]};
			default: rd_val = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= RST_ZERO;
			s_axi_rresp <= 2'b00;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_val;
			s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// whole-word writes to config, write strobes ignored; command register acts on write only
	logic wr_ok, cmd_stb;
	logic [3:0] cmd;
	assign wr_ok = wr_go && wr_hit;
	assign cmd_stb = wr_ok && awaddr_q == REG_CMD;
	assign cmd = wdata_q[3:0];

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			ctrl_q <= '0;
			txcfg_q <= 8'h00;
			ovpat_q <= '0;
			unpat_q <= '0;
			ntx_q <= 10'h000;
			txwl_q <= 9'h000;
			rxwl_q <= 9'h000;
		end else if (wr_ok) begin
			unique case (awaddr_q)
				REG_CTRL: ctrl_q <= wdata_q[8:0];
				REG_TXCFG: txcfg_q <= wdata_q[7:0];
				REG_OVPAT: ovpat_q <= wdata_q[PAT_LEN-1:0];
				REG_UNPAT: unpat_q <= wdata_q[PAT_LEN-1:0];
				REG_NTX: ntx_q <= wdata_q[9:0];
				REG_WLVL: begin
					txwl_q <= wdata_q[8:0];
					rxwl_q <= wdata_q[24:16];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (wr_ok && awaddr_q == REG_PTMEM && wdata_q[21:16] < 6'(PT_DEPTH)) begin
			ptm[wdata_q[21:16]] <= wdata_q[7:0];
		end
	end

	//------------------------------------------------------------
	// oscillator start and listen selection
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_ok_q <= 1'b0;
		end else begin
			osc_s1_q <= osc_stable_i;
			osc_s2_q <= osc_s1_q;
			osc_ok_q <= osc_s2_q && ctrl_q.en;
		end
	end
	assign osc_en_o = ctrl_q.en;
	assign modulation_depth_sel_o = txcfg_q[3:0];
	assign listen_o = ctrl_q.targ;
	assign fixed_listen_o = ctrl_q.targ && !ctrl_q.operating_mode_field[3];
	assign bitrate_det_o = ctrl_q.targ && ctrl_q.operating_mode_field[3];
	assign tech_o = ctrl_q.operating_mode_field[2:0];

	//------------------------------------------------------------
	// carrier tick and transceive engine
	//------------------------------------------------------------
	logic [4:0] cdiv_q;
	logic ctick;
	assign ctick = cdiv_q == 5'(CARR_CYC - 1);
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || ctick) begin
			cdiv_q <= 5'h00;
		end else begin
			cdiv_q <= cdiv_q + 5'h01;
		end
	end

	ntx_src_e src_q;
	logic [9:0] left_q;
	logic [7:0] sh_q, fix_q;
	logic [5:0] pta_q;
	logic [2:0] bit_q;
	logic [6:0] bt_q;
	logic start, eob, last, tx_pop, mod_d, mod_q;
	logic [9:0] start_len;
	logic [5:0] start_pta;
	ntx_src_e start_src;
	logic [7:0] fetch;

	// automatic target answers only in passive fixed listen, engine free
	logic pt_auto, a_wake, a_sel, f_req;
	assign pt_auto = fixed_listen_o && eng_q == E_IDLE;
	assign a_wake = pt_auto && (pt_evt_i.wupa || (pt_evt_i.reqa && pt_q == PT_SENSE));
	assign a_sel = pt_auto && pt_evt_i.sel && pt_q == PT_READY;
	assign f_req = pt_auto && pt_evt_i.sensf_req;

	always_comb begin
		start = 1'b0;
		start_len = ntx_q;
		start_pta = PT_SENS_RES;
		start_src = SRC_FIFO;
		if (eng_q == E_IDLE && cmd_stb && cmd inside {CMD_TX, CMD_REQA, CMD_WUPA}) begin
			start = 1'b1;
			if (cmd != CMD_TX) begin
				start_src = SRC_FIX;
				start_len = 10'h001;
			end
		end else if (a_wake) begin
			start = 1'b1;
			start_src = SRC_PT;
			start_len = LEN_SENS_RES;
		end else if (a_sel) begin
			start = 1'b1;
			start_src = SRC_PT;
			start_pta = PT_SAK;
			start_len = LEN_SAK;
		end else if (f_req) begin
			start = 1'b1;
			start_src = SRC_PT;
			start_pta = PT_SENSF;
			start_len = LEN_SENSF;
		end
	end

	assign fetch = src_q == SRC_PT ? ptm[pta_q] : (src_q == SRC_FIX ? fix_q : fifo[rd_ptr_q]);
	assign eob = eng_q == E_TX && ctick && bt_q == CARR_PER_BIT && bit_q == 3'h7;
	assign last = left_q <= 10'h001;
	assign tx_pop = eob && src_q == SRC_FIFO && fcnt_q != 10'h000;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			eng_q <= E_IDLE;
			src_q <= SRC_FIFO;
			left_q <= 10'h000;
			sh_q <= 8'h00;
			fix_q <= 8'h00;
			pta_q <= 6'h00;
			bit_q <= 3'h0;
			bt_q <= 7'h00;
		end else if (cmd_stb && cmd == CMD_STOP) begin
			eng_q <= E_IDLE;
		end else begin
			unique case (eng_q)
				E_IDLE: if (start) begin
					eng_q <= E_TX;
					src_q <= start_src;
					left_q <= start_len;
					pta_q <= start_pta;
					fix_q <= cmd == CMD_WUPA ? BYTE_WUPA : BYTE_REQA;
					bit_q <= 3'h0;
					bt_q <= 7'h00;
					sh_q <= 8'h00;
				end
				E_TX: if (ctick) begin
					bt_q <= bt_q + 7'h01;
					if (bt_q == 7'h00 && bit_q == 3'h0) begin
						sh_q <= fetch;
					end else if (bt_q == CARR_PER_BIT) begin
						sh_q <= {1'b0, sh_q[7:1]};
						bit_q <= bit_q + 3'h1;
					end
					if (eob) begin
						left_q <= left_q - 10'h001;
						pta_q <= pta_q + 6'h01;
						if (last) begin
							eng_q <= E_RX;
						end
					end
				end
				E_RX: if (rx_evt_i.done) begin
					eng_q <= E_IDLE;
				end
				default: eng_q <= E_IDLE;
			endcase
		end
	end

	logic rx_q;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			rx_q <= 1'b0;
			rssi_start_o <= 1'b0;
		end else begin
			rx_q <= eng_q == E_RX;
			rssi_start_o <= eng_q == E_RX && !rx_q;
		end
	end
	assign rx_watch_o = rx_q;
	assign agc_run_o = rx_q && ctrl_q.agc_en;

	//------------------------------------------------------------
	// fifo shared by transmit and receive
	//------------------------------------------------------------
	logic push, pop, rx_push, host_push, host_pop;
	logic [7:0] push_data;
	assign rx_push = eng_q == E_RX && rx_evt_i.valid;
	assign host_push = wr_ok && awaddr_q == REG_FIFO;
	assign host_pop = rd_go && s_axi_araddr == REG_FIFO && fcnt_q != 10'h000;
	assign push = (rx_push || host_push) && fcnt_q != 10'(FIFO_DEPTH);
	assign push_data = rx_push ? rx_evt_i.data : wdata_q[7:0];
	assign pop = tx_pop || (host_pop && eng_q != E_TX);

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			fifo[wr_ptr_q] <= push_data;
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || (cmd_stb && cmd == CMD_STOP)) begin
			wr_ptr_q <= 9'h000;
			rd_ptr_q <= 9'h000;
			fcnt_q <= 10'h000;
		end else begin
			wr_ptr_q <= wr_ptr_q + {8'h00, push};
			rd_ptr_q <= rd_ptr_q + {8'h00, pop};
			fcnt_q <= fcnt_q + {9'h000, push} - {9'h000, pop};
		end
	end

	//------------------------------------------------------------
	// passive target state
	//------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pt_q <= PT_SENSE;
		end else if (cmd_stb && cmd == CMD_SENSE) begin
			pt_q <= PT_SENSE;
		end else if (cmd_stb && cmd == CMD_SLEEP) begin
			pt_q <= PT_SLEEP;
		end else if (a_wake) begin
			pt_q <= PT_READY;
		end else if (a_sel) begin
			pt_q <= PT_ACTIVE;
		end
	end

	//------------------------------------------------------------
	// sticky flags, write one to clear, set wins
	//------------------------------------------------------------
	logic fcnt_lo_q, fcnt_hi_q, fcnt_lo, fcnt_hi;
	assign fcnt_lo = eng_q == E_TX && src_q == SRC_FIFO && fcnt_q < {1'b0, txwl_q};
	assign fcnt_hi = eng_q == E_RX && fcnt_q > {1'b0, rxwl_q};
	always_comb begin
		flag_set = '0;
		flag_set[FL_OSC] = osc_s2_q && ctrl_q.en && !osc_ok_q;
		flag_set[FL_EOT] = eob && last;
		flag_set[FL_EOR] = eng_q == E_RX && rx_evt_i.done;
		flag_set[FL_ERR] = eng_q == E_RX && rx_evt_i.err;
		flag_set[FL_COLL] = eng_q == E_RX && rx_evt_i.coll;
		flag_set[FL_TXWL] = fcnt_lo && !fcnt_lo_q;
		flag_set[FL_RXWL] = fcnt_hi && !fcnt_hi_q;
		flag_set[FL_WUA] = a_wake;
		flag_set[FL_WUF] = f_req;
	end
	assign flag_clr = wr_ok && awaddr_q == REG_FLAGS ? wdata_q[NFLAG-1:0] : '0;
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			flags_q <= '0;
			fcnt_lo_q <= 1'b0;
			fcnt_hi_q <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			flags_q <= (flags_q & ~flag_clr) | flag_set;
			fcnt_lo_q <= fcnt_lo;
			fcnt_hi_q <= fcnt_hi;
			irq_o <= |flags_q;
		end
	end

	//------------------------------------------------------------
	// transition drive pattern sequencer
	//------------------------------------------------------------
	// modulated while the bit being sent is zero, past its first carrier cycle; transitions land on carrier ticks
	logic [3:0] seq_q, seq_d;
	logic up_q, up_d, trans;
	logic [PAT_LEN-1:0] pat;
	logic [1:0] tmode;
	ntx_drv_e drv_d, drv_norm;
	assign mod_d = eng_q == E_TX && ctrl_q.tx_en && !sh_q[0] && bt_q != 7'h00;
	assign trans = ctick && mod_d != mod_q;
	always_comb begin
		seq_d = seq_q;
		up_d = up_q;
		if (trans) begin
			seq_d = 4'h0;
			up_d = mod_d;
		end else if (ctick && seq_q != 4'(PAT_LEN)) begin
			seq_d = seq_q + 4'h1;
		end
		pat = up_d ? unpat_q : ovpat_q;
		tmode = up_d ? txcfg_q[7:6] : txcfg_q[5:4];
		drv_norm = !ctrl_q.tx_en ? DRV_OFF : ((trans ? mod_d : mod_q) ? DRV_AM : DRV_DR);
		drv_d = drv_norm;
		if (seq_d != 4'(PAT_LEN) && pat[seq_d]) begin
			unique case (tmode)
				2'b00: drv_d = DRV_DR;
				2'b01: drv_d = DRV_AM;
				2'b10: drv_d = DRV_STOP;
				default: drv_d = drv_norm;
			endcase
		end
	end
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			seq_q <= 4'(PAT_LEN);
			up_q <= 1'b0;
			mod_q <= 1'b0;
			drv_o <= DRV_OFF;
		end else begin
			seq_q <= seq_d;
			up_q <= up_d;
			if (ctick) begin
				mod_q <= mod_d;
			end
			drv_o <= drv_d;
		end
	end

	//------------------------------------------------------------
	// assertions
	//------------------------------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	a_pattern_restart: assert property (trans |=> seq_q == 4'h0)
		else $error("sequencer did not restart on transition");
	a_pattern_zero: assert property (seq_q == 4'(PAT_LEN) && !trans |=> drv_o == $past(drv_norm))
		else $error("normal drive not applied after pattern");
	a_pattern_stop: assert property (trans && !mod_d && ovpat_q[0] && txcfg_q[5:4] == 2'b10
		|=> drv_o == DRV_STOP)
		else $error("first overshoot cycle not stopped");
	a_fifo_bound: assert property (fcnt_q <= 10'(FIFO_DEPTH))
		else $error("fifo count beyond depth");
	a_eot_to_rx: assert property (flag_set[FL_EOT] |=> eng_q == E_RX ##1 rx_watch_o)
		else $error("receiver not started after transmit");
	a_eor_flag: assert property (eng_q == E_RX && rx_evt_i.done && !cmd_stb
		|=> flags_q[FL_EOR] && eng_q == E_IDLE)
		else $error("end of receive not flagged");
	a_err_flag: assert property (eng_q == E_RX && (rx_evt_i.err || rx_evt_i.coll)
		|=> flags_q[FL_ERR] || flags_q[FL_COLL])
		else $error("receive error not flagged");
	a_set_wins: assert property (flag_set[FL_WUA] |=> flags_q[FL_WUA])
		else $error("wake flag lost to clear");
	a_sleep_cmd: assert property (cmd_stb && cmd == CMD_SLEEP |=> pt_q == PT_SLEEP)
		else $error("go to sleep ignored");
	a_osc_flag: assert property ($rose(osc_ok_q) |-> $past(flag_set[FL_OSC]))
		else $error("oscillator flag missing");
	a_bitrate_sel: assert property (bitrate_det_o |-> !fixed_listen_o && listen_o)
		else $error("listen variant inconsistent");

	c_transceive: cover property (flag_set[FL_EOT] ##[1:1000] flag_set[FL_EOR]);
	c_auto_sak: cover property (a_sel);
	c_overshoot: cover property (trans ##1 drv_o == DRV_STOP);
	c_rx_water: cover property (flag_set[FL_RXWL]);
endmodule

// ===== sim/ntx_host_model.sv
// axi4-lite host model issuing register writes and reads
`timescale 1ns/1ps
module ntx_host_model (
	// clock
	input wire logic clk_sys_i,
	// write channels
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	// read channels
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
	end
	// address and data offered together; each released at its own taking edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic wd;
		@(posedge clk_sys_i);
		aw = 1'b1;
		wd = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (aw || wd) begin
			@(posedge clk_sys_i);
			if (s_axi_awready) aw = 1'b0;
			if (s_axi_wready) wd = 1'b0;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= wd;
		end
		do @(posedge clk_sys_i); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys_i); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys_i); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ===== sim/testbench.sv
// self-checking bench for the nfc front-end control block
`timescale 1ns/1ps
module testbench;
	import ntx_pkg::*;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic osc_stable_i = 1'b0;
	ntx_rx_evt_s rx_evt_i = '0;
	ntx_pt_evt_s pt_evt_i = '0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, modulation_depth_sel_o;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic osc_en_o, rx_watch_o, rssi_start_o, agc_run_o, listen_o, fixed_listen_o;
	logic bitrate_det_o, irq_o;
	logic [2:0] tech_o;
	ntx_drv_e drv_o;
	int errors = 0;
	int checked = 0;
	// field guard before the first command, scaled down to keep the run short
	localparam int GUARD_CYC = 1000;
	always #2 clk_sys_i = ~clk_sys_i;
	ntx_core i_ntx_core (.clk_sys_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .osc_stable_i, .rx_evt_i, .pt_evt_i, .osc_en_o,
		.modulation_depth_sel_o, .drv_o, .rx_watch_o, .rssi_start_o, .agc_run_o, .listen_o,
		.fixed_listen_o, .bitrate_det_o, .tech_o, .irq_o);
	ntx_host_model i_ntx_host_model (.clk_sys_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	//------------------------------------------------------------
	// shared helpers
	//------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		i_ntx_host_model.wr(a, d, r);
		chk("bresp", 32'(r), 32'(er));
	endtask
	task automatic rr(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		i_ntx_host_model.rd(a, d, r);
	endtask
	task automatic report_and_stop;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	//------------------------------------------------------------
	// scenarios
	//------------------------------------------------------------
	task automatic t_ready;
		logic [31:0] d;
		chk("drv_rst", 32'(drv_o), 32'(DRV_OFF));
		w(REG_CTRL, 32'h0000_0001, 2'b00);
		chk("osc_en", 32'(osc_en_o), 32'h1);
		osc_stable_i <= 1'b1;
		repeat (8) @(posedge clk_sys_i);
		rr(REG_FLAGS, d);
		chk("osc_flag", 32'(d[FL_OSC]), 32'h1);
		rr(REG_STAT, d);
		chk("osc_ok", 32'(d[0]), 32'h1);
		chk("irq", 32'(irq_o), 32'h1);
	endtask
	task automatic t_depth;
		for (int i = 0; i < 16; i++) begin
			w(REG_TXCFG, 32'(i), 2'b00);
			chk("depth", 32'(modulation_depth_sel_o), 32'(i));
		end
	endtask
	task automatic t_listen;
		logic [3:0] m;
		for (int i = 0; i < 2; i++) begin
			m = i ? 4'hb : 4'h5;
			w(REG_CTRL, {24'h0, m, 4'h9}, 2'b00);
			chk("listen", 32'(listen_o), 32'h1);
			chk("fixed", 32'(fixed_listen_o), 32'(!m[3]));
			chk("bitrate", 32'(bitrate_det_o), 32'(m[3]));
			chk("tech", 32'(tech_o), 32'(m[2:0]));
		end
	endtask
	task automatic t_txrx;
		logic [31:0] d;
		int n;
		w(REG_CTRL, 32'h0000_0107, 2'b00);
		repeat (GUARD_CYC) @(posedge clk_sys_i);
		w(REG_CMD, 32'(CMD_STOP), 2'b00);
		w(REG_FLAGS, 32'h0000_01ff, 2'b00);
		w(REG_NTX, 32'h0000_0001, 2'b00);
		w(REG_CMD, 32'(CMD_REQA), 2'b00);
		n = 0;
		while (rx_watch_o !== 1'b1 && n < 40000) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk("watch", 32'(rx_watch_o), 32'h1);
		chk("rssi", 32'(rssi_start_o), 32'h1);
		chk("agc", 32'(agc_run_o), 32'h1);
		rx_evt_i <= {1'b1, 8'ha5, 3'b000};
		@(posedge clk_sys_i);
		rx_evt_i <= {1'b0, 8'h00, 3'b011};
		@(posedge clk_sys_i);
		rx_evt_i <= {1'b0, 8'h00, 3'b100};
		@(posedge clk_sys_i);
		rx_evt_i <= '0;
		repeat (2) @(posedge clk_sys_i);
		rr(REG_FLAGS, d);
		chk("eot", 32'(d[FL_EOT]), 32'h1);
		chk("eor", 32'(d[FL_EOR]), 32'h1);
		chk("err_coll", 32'({d[FL_ERR], d[FL_COLL]}), 32'h3);
		chk("rx_water", 32'(d[FL_RXWL]), 32'h1);
		rr(REG_STAT, d);
		chk("count", 32'(d[13:4]), 32'h1);
		rr(REG_FIFO, d);
		chk("rx_byte", 32'(d[7:0]), 32'h0000_00a5);
	endtask
	// undershoot stop window length and the drive after it, tx water level
	task automatic t_shape;
		logic [31:0] d;
		int n;
		w(REG_TXCFG, 32'h0000_00a0, 2'b00);
		w(REG_UNPAT, 32'h0000_0001, 2'b00);
		w(REG_OVPAT, 32'h0000_0001, 2'b00);
		w(REG_WLVL, 32'h0000_0002, 2'b00);
		w(REG_FIFO, 32'h0000_0000, 2'b00);
		w(REG_NTX, 32'h0000_0002, 2'b00);
		w(REG_CMD, 32'(CMD_TX), 2'b00);
		n = 0;
		while (drv_o !== DRV_STOP && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		n = 0;
		while (drv_o === DRV_STOP && n < 200) begin
			@(posedge clk_sys_i);
			n++;
		end
		chk("stop_len", 32'(n), 32'(CARR_CYC));
		chk("drv_after", 32'(drv_o), 32'(DRV_AM));
		w(REG_FIFO, 32'h0000_0055, 2'b00);
		rr(REG_FLAGS, d);
		chk("tx_water", 32'(d[FL_TXWL]), 32'h1);
		w(REG_CMD, 32'(CMD_STOP), 2'b00);
	endtask
	// automatic target answers, wake and request flags, sleep command
	task automatic t_target;
		logic [31:0] d;
		w(REG_CTRL, 32'h0000_0059, 2'b00);
		w(REG_PTMEM, 32'h000a_0044, 2'b00);
		w(REG_PTMEM, 32'h0011_0001, 2'b00);
		pt_evt_i <= 4'b1000;
		@(posedge clk_sys_i);
		pt_evt_i <= '0;
		rr(REG_STAT, d);
		chk("auto_tx", 32'(d[3:1]), 32'(E_TX));
		chk("pt_ready", 32'(d[17:14]), 32'(PT_READY));
		w(REG_CMD, 32'(CMD_STOP), 2'b00);
		pt_evt_i <= 4'b0001;
		@(posedge clk_sys_i);
		pt_evt_i <= '0;
		w(REG_CMD, 32'(CMD_STOP), 2'b00);
		w(REG_CMD, 32'(CMD_SLEEP), 2'b00);
		rr(REG_FLAGS, d);
		chk("wake_req", 32'(d[FL_WUF:FL_WUA]), 32'h3);
		rr(REG_STAT, d);
		chk("pt_sleep", 32'(d[17:14]), 32'(PT_SLEEP));
	endtask
	task automatic t_refuse;
		logic [31:0] d;
		logic [1:0] r;
		i_ntx_host_model.rd(8'h30, d, r);
		chk("rresp", 32'(r), 32'h2);
		w(REG_STAT, 32'h0, 2'b10);
	endtask
	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		t_ready();
		t_depth();
		t_listen();
		t_txrx();
		t_shape();
		t_target();
		t_refuse();
		report_and_stop();
	end
	// whole run is about 20k cycles; this cuts a hang
	initial begin
		repeat (80000) @(posedge clk_sys_i);
		errors++;
		report_and_stop();
	end
endmodule
